// file: hdl/adcc_ctrl.sv
// Function
// - Active flag sets on conversion start, clears on completion or abort.
// - Trigger select: 0 starts on control-one write, 1 on hardware trigger.
// - Control-two bit 5 enables automatic compare.
// - Direction bit 4: 0 less-than, 1 greater-or-equal compare.
// - High result holds upper two bits; zero in 8-bit mode.
// - Results load each completion unless compare enabled and false.
// - 10-bit: high result read locks results until low result read.
// - 8-bit: no read interlock, every result transferred.
// - Results undefined after resolution change until next completion.
// - Low result holds lower eight bits or whole 8-bit result.
// - 10-bit compare uses high compare bits; 8-bit ignores them.
// - Low compare byte compared with lower eight result bits.
// - Config bit 7 selects high-speed or low-power converter setting.
// - Divider bits 6:5 divide input clock by 1, 2, 4, 8.
// - Config bit 4 selects short or long sample period.
// - Resolution bits 3:2: 00 8-bit, 10 10-bit, others reserved.
// - Source bits 1:0: bus, bus halved, alternate, asynchronous clock.
// - Complete flag sets on qualified completion; clears on control-one write or low read.
// - Control-one write aborts; with trigger select 0, starts unless channel is all ones.
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module adcc_ctrl (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [7:0]             awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [7:0]             araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire logic                   hardware_trigger_in,
   input  wire logic                   alternate_clock,
   input  wire logic                   async_converter_clock,
   input  wire logic                   core_done,
   input  wire logic [9:0]             core_result,
   output adcc_pkg::adcc_core_req_s    core_req
);
   // ****************************************
   // Functions
   // ****************************************
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == adcc_pkg::OFF_SC1) || (a == adcc_pkg::OFF_SC2) ||
               (a == adcc_pkg::OFF_RH)  || (a == adcc_pkg::OFF_RL)  ||
               (a == adcc_pkg::OFF_CVH) || (a == adcc_pkg::OFF_CVL) ||
               (a == adcc_pkg::OFF_CFG);
   endfunction

   function automatic logic [2:0] div_last(input logic [1:0] d);
      div_last = 3'((4'h1 << d) - 4'h1);
   endfunction

   // ****************************************
   // State
   // ****************************************
   adcc_pkg::adcc_state_s s;
   adcc_pkg::adcc_state_s next_s;
   logic        do_write;
   logic        wr_sc1;
   logic        rd_rh;
   logic        rd_rl;
   logic        mode10;
   logic        done;
   logic        cmp_true;
   logic        qualified;
   logic        hw_rise;
   logic        src_tick;
   logic [9:0]  res;
   logic [9:0]  cv;
   logic [3:0]  key;

   assign awready = (s.wst == adcc_pkg::ADCC_W_IDLE) && !s.aw_got;
   assign wready  = (s.wst == adcc_pkg::ADCC_W_IDLE) && !s.w_got;
   assign arready = !s.rvalid;
   assign bvalid  = s.bvalid;
   assign bresp   = s.bresp;
   assign rvalid  = s.rvalid;
   assign rresp   = s.rresp;
   assign rdata   = {24'h00_0000, s.rdata};

   assign core_req.start       = s.start_p;
   assign core_req.abort       = s.abort_p;
   assign core_req.clk_en      = s.ck_en;
   assign core_req.channel     = s.chan;
   assign core_req.ten_bit     = mode10;
   assign core_req.low_power   = s.cfg[adcc_pkg::CFG_LP_BIT];
   assign core_req.long_sample = s.cfg[adcc_pkg::CFG_LSMP_BIT];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;
      next_s.start_p = 1'b0;
      next_s.abort_p = 1'b0;
      next_s.ck_en   = 1'b0;
      next_s.hwt_q   = hardware_trigger_in;
      next_s.alt_q   = alternate_clock;
      next_s.asy_q   = async_converter_clock;
      next_s.half_tog = !s.half_tog;
      hw_rise = hardware_trigger_in && !s.hwt_q;
      mode10 = (s.cfg[adcc_pkg::CFG_MODE_LSB +: 2] == adcc_pkg::MODE_10);
      // Compare operands
      res = mode10 ? core_result : {2'b00, core_result[7:0]};
      cv  = mode10 ? {s.cvh, s.cvl} : {2'b00, s.cvl};
      cmp_true = s.cmp_dir ? (res >= cv) : (res < cv);
      qualified = !s.cmp_en || cmp_true;
      done = core_done && s.active;
      // Write channel
      do_write = 1'b0;
      case (s.wst)
         adcc_pkg::ADCC_W_IDLE: begin
            if (awvalid && awready) begin
               next_s.aw_got = 1'b1;
               next_s.waddr  = awaddr;
            end
            if (wvalid && wready) begin
               next_s.w_got = 1'b1;
               next_s.wbyte = wdata[7:0];
               next_s.wlane = wstrb[0];
            end
            if (s.aw_got && s.w_got) begin
               do_write      = 1'b1;
               next_s.aw_got = 1'b0;
               next_s.w_got  = 1'b0;
               next_s.bvalid = 1'b1;
               next_s.bresp  = mapped(s.waddr) ? adcc_pkg::RESP_OKAY
                                               : adcc_pkg::RESP_SLVERR;
               next_s.wst    = adcc_pkg::ADCC_W_RESP;
            end
         end
         adcc_pkg::ADCC_W_RESP: begin
            if (bready) begin
               next_s.bvalid = 1'b0;
               next_s.wst    = adcc_pkg::ADCC_W_IDLE;
            end
         end
         default: begin
            next_s.wst = adcc_pkg::ADCC_W_IDLE;
         end
      endcase
      do_write = do_write && s.wlane;
      wr_sc1 = do_write && (s.waddr == adcc_pkg::OFF_SC1);
      if (do_write && s.waddr == adcc_pkg::OFF_SC2) begin
         // Bits 7 and 3:0 are not writable
         next_s.trg     = s.wbyte[adcc_pkg::SC2_TRG_BIT];
         next_s.cmp_en  = s.wbyte[adcc_pkg::SC2_CMPEN_BIT];
         next_s.cmp_dir = s.wbyte[adcc_pkg::SC2_CMPDIR_BIT];
      end
      if (do_write && s.waddr == adcc_pkg::OFF_CVH) begin
         next_s.cvh = s.wbyte[1:0];
      end
      if (do_write && s.waddr == adcc_pkg::OFF_CVL) begin
         next_s.cvl = s.wbyte;
      end
      if (do_write && s.waddr == adcc_pkg::OFF_CFG) begin
         next_s.cfg = s.wbyte;
         if (s.wbyte[adcc_pkg::CFG_MODE_LSB +: 2] != s.cfg[adcc_pkg::CFG_MODE_LSB +: 2]) begin
            next_s.lock = 1'b0;
         end
      end
      // Read channel
      rd_rh = 1'b0;
      rd_rl = 1'b0;
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = mapped(araddr) ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
         rd_rh = (araddr == adcc_pkg::OFF_RH);
         rd_rl = (araddr == adcc_pkg::OFF_RL);
         case (araddr)
            adcc_pkg::OFF_SC1: next_s.rdata = {s.conversion_complete_flag, 1'b0, s.cont, s.chan};
            adcc_pkg::OFF_SC2: next_s.rdata = {s.active, s.trg, s.cmp_en,
                                               s.cmp_dir, 4'h0};
            adcc_pkg::OFF_RH:  next_s.rdata = {6'h00, mode10 ? s.rh : 2'b00};
            adcc_pkg::OFF_RL:  next_s.rdata = s.rl;
            adcc_pkg::OFF_CVH: next_s.rdata = {6'h00, s.cvh};
            adcc_pkg::OFF_CVL: next_s.rdata = s.cvl;
            adcc_pkg::OFF_CFG: next_s.rdata = s.cfg;
            default:           next_s.rdata = 8'h00;
         endcase
      end
      if (rd_rh && mode10) begin
         next_s.lock = 1'b1;
      end
      if (rd_rl) begin
         next_s.lock = 1'b0;
         next_s.conversion_complete_flag = 1'b0;
      end
      // Conversion control
      if (wr_sc1) begin
         next_s.chan = s.wbyte[4:0];
         next_s.cont = s.wbyte[adcc_pkg::SC1_CONT_BIT];
         next_s.conversion_complete_flag = 1'b0;
         next_s.abort_p = s.active;
         next_s.active  = 1'b0;
         if (!s.trg && s.wbyte[4:0] != adcc_pkg::CHAN_OFF) begin
            next_s.start_p = 1'b1;
            next_s.active  = 1'b1;
         end
      end else if (done) begin
         next_s.active = 1'b0;
         if (qualified) begin
            next_s.conversion_complete_flag = 1'b1;
            if (!(s.lock && mode10)) begin
               next_s.rh = res[9:8];
               next_s.rl = res[7:0];
            end
         end
         if (s.cont && !s.trg && s.chan != adcc_pkg::CHAN_OFF) begin
            next_s.start_p = 1'b1;
            next_s.active  = 1'b1;
         end
      end else if (hw_rise && s.trg && !s.active && s.chan != adcc_pkg::CHAN_OFF) begin
         next_s.start_p = 1'b1;
         next_s.active  = 1'b1;
      end
      // Converter clock divider
      case (s.cfg[adcc_pkg::CFG_SRC_LSB +: 2])
         adcc_pkg::SRC_BUS:   src_tick = 1'b1;
         adcc_pkg::SRC_HALF:  src_tick = s.half_tog;
         adcc_pkg::SRC_ALT:   src_tick = alternate_clock && !s.alt_q;
         adcc_pkg::SRC_ASYNC: src_tick = async_converter_clock && !s.asy_q;
         default:             src_tick = 1'b0;
      endcase
      key = {s.cfg[adcc_pkg::CFG_DIV_LSB +: 2], s.cfg[adcc_pkg::CFG_SRC_LSB +: 2]};
      if (key != s.div_key) begin
         next_s.div_key = key;
         next_s.div_cnt = 3'h0;
      end else if (src_tick) begin
         if (s.div_cnt == div_last(s.cfg[adcc_pkg::CFG_DIV_LSB +: 2])) begin
            next_s.div_cnt = 3'h0;
            next_s.ck_en   = 1'b1;
         end else begin
            next_s.div_cnt = s.div_cnt + 3'h1;
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s         <= '0;
         s.wst     <= adcc_pkg::ADCC_W_IDLE;
         s.chan    <= adcc_pkg::CHAN_OFF;
         s.cfg     <= adcc_pkg::CFG_RST;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   active_on_start_a: assert property (s.start_p |-> s.active)
      else $error("active flag low at conversion start");
   active_on_done_a: assert property (done && !wr_sc1 && !s.cont |=> !s.active)
      else $error("active flag not cleared at completion");
   abort_clears_a: assert property (wr_sc1 && s.active |=> s.abort_p)
      else $error("abort not issued on control-one write");
   sw_start_a: assert property (wr_sc1 && !s.trg && s.wbyte[4:0] != adcc_pkg::CHAN_OFF
                                |=> s.start_p ##1 !s.start_p)
      else $error("software start missing");
   hw_start_a: assert property (hw_rise && s.trg && !s.active && !wr_sc1 &&
                                s.chan != adcc_pkg::CHAN_OFF |=> s.start_p)
      else $error("hardware start missing");
   cmp_hold_a: assert property (done && !wr_sc1 && s.cmp_en && !cmp_true
                                |=> $stable(s.rl) && $stable(s.rh) && !$rose(s.conversion_complete_flag))
      else $error("result changed on false compare");
   lock_hold_a: assert property (done && !wr_sc1 && s.lock && mode10 |=> $stable(s.rl))
      else $error("locked result overwritten");
   load_res_a: assert property (done && !wr_sc1 && qualified && !(s.lock && mode10)
                                |=> s.rl == $past(res[7:0]) && s.conversion_complete_flag)
      else $error("result or complete flag not updated");
   conversion_complete_flag_clear_a: assert property (wr_sc1 |=> !s.conversion_complete_flag)
      else $error("complete flag not cleared by write");

   sw_conv_c: cover property (s.start_p ##[1:200] done);
   cmp_block_c: cover property (done && s.cmp_en && !cmp_true);
   lock_drop_c: cover property (done && s.lock && mode10);
   div8_c: cover property (s.ck_en && s.cfg[adcc_pkg::CFG_DIV_LSB +: 2] == 2'h3);
   cont_c: cover property (done && s.cont ##1 s.start_p);
endmodule // adcc_ctrl
`default_nettype wire

// file: hdl/adcc_pkg.sv
`default_nettype none
package adcc_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam int unsigned ADDR_W    = 8;
   localparam logic [7:0]  OFF_SC1   = 8'h00;
   localparam logic [7:0]  OFF_SC2   = 8'h04;
   localparam logic [7:0]  OFF_RH    = 8'h08;
   localparam logic [7:0]  OFF_RL    = 8'h0C;
   localparam logic [7:0]  OFF_CVH   = 8'h10;
   localparam logic [7:0]  OFF_CVL   = 8'h14;
   localparam logic [7:0]  OFF_CFG   = 8'h18;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int unsigned SC1_CONVERSION_COMPLETE_FLAG_BIT = 7;
   localparam int unsigned SC1_CONT_BIT = 5;
   localparam int unsigned SC2_ACT_BIT  = 7;
   localparam int unsigned SC2_TRG_BIT  = 6;
   localparam int unsigned SC2_CMPEN_BIT = 5;
   localparam int unsigned SC2_CMPDIR_BIT = 4;
   localparam int unsigned CFG_LP_BIT   = 7;
   localparam int unsigned CFG_DIV_LSB  = 5;
   localparam int unsigned CFG_LSMP_BIT = 4;
   localparam int unsigned CFG_MODE_LSB = 2;
   localparam int unsigned CFG_SRC_LSB  = 0;
   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [4:0] CHAN_OFF   = 5'h1F;
   localparam logic [7:0] CFG_RST    = 8'h00;
   localparam logic [1:0] MODE_8     = 2'h0;
   localparam logic [1:0] MODE_10    = 2'h2;
   localparam logic [1:0] SRC_BUS    = 2'h0;
   localparam logic [1:0] SRC_HALF   = 2'h1;
   localparam logic [1:0] SRC_ALT    = 2'h2;
   localparam logic [1:0] SRC_ASYNC  = 2'h3;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      ADCC_W_IDLE = 2'b01,
      ADCC_W_RESP = 2'b10
   } adcc_wst_e;
   typedef struct packed {
      logic       start;
      logic       abort;
      logic       clk_en;
      logic [4:0] channel;
      logic       ten_bit;
      logic       low_power;
      logic       long_sample;
   } adcc_core_req_s;
   typedef struct packed {
      adcc_wst_e   wst;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  waddr;
      logic [7:0]  wbyte;
      logic        wlane;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic [4:0]  chan;
      logic        cont;
      logic        conversion_complete_flag;
      logic        active;
      logic        trg;
      logic        cmp_en;
      logic        cmp_dir;
      logic [7:0]  cfg;
      logic [1:0]  cvh;
      logic [7:0]  cvl;
      logic [1:0]  rh;
      logic [7:0]  rl;
      logic        lock;
      logic        hwt_q;
      logic        alt_q;
      logic        asy_q;
      logic        half_tog;
      logic [2:0]  div_cnt;
      logic [3:0]  div_key;
      logic        start_p;
      logic        abort_p;
      logic        ck_en;
   } adcc_state_s;
endpackage
`default_nettype wire

// file: sim/adcc_core_model.sv
`default_nettype none
module adcc_core_model (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire adcc_pkg::adcc_core_req_s core_req,
   input  wire logic [9:0]               next_result,
   input  wire logic [7:0]               conv_len,
   output logic                          core_done,
   output logic [9:0]                    core_result
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy;
   logic [7:0] ticks;
   // ****************
   // Conversion counted in converter clocks
   // ****************
   always_ff @(posedge aclk) begin
      core_done <= 1'b0;
      core_result <= ~core_result;
      if (!aresetn) begin
         busy <= 1'b0;
         ticks <= 8'h00;
         core_result <= 10'h000;
      end else if (core_req.start) begin
         busy <= 1'b1;
         ticks <= 8'h00;
      end else if (core_req.abort) begin
         busy <= 1'b0;
      end else if (busy && core_req.clk_en) begin
         ticks <= ticks + 8'h01;
         if (ticks + 8'h01 >= conv_len) begin
            busy <= 1'b0;
            core_done <= 1'b1;
            core_result <= next_result;
         end
      end
   end
endmodule // adcc_core_model
`default_nettype wire

// file: sim/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] sc2;
      logic [9:0] cv;
      logic [9:0] res;
      logic [9:0] exp;
      logic       conversion_complete_flag;
   } adcc_row_s;
   localparam adcc_row_s ROWS [10] = '{
      '{8'h00, 8'h00, 10'h000, 10'h3A5, 10'h0A5, 1'b1},
      '{8'h08, 8'h00, 10'h000, 10'h3A5, 10'h3A5, 1'b1},
      '{8'h88, 8'h20, 10'h300, 10'h2F0, 10'h2F0, 1'b1},
      '{8'h18, 8'h20, 10'h100, 10'h1FF, 10'h2F0, 1'b0},
      '{8'h69, 8'h30, 10'h100, 10'h1FF, 10'h1FF, 1'b1},
      '{8'h2A, 8'h30, 10'h300, 10'h2AA, 10'h1FF, 1'b0},
      '{8'h03, 8'h30, 10'h310, 10'h020, 10'h020, 1'b1},
      '{8'h40, 8'h20, 10'h210, 10'h305, 10'h005, 1'b1},
      '{8'h04, 8'h00, 10'h000, 10'h2C3, 10'h0C3, 1'b1},
      '{8'h0C, 8'h00, 10'h000, 10'h1D4, 10'h0D4, 1'b1}
   };
   localparam int         SRC_T [4] = '{1, 2, 6, 10};
   localparam logic [7:0] RST_A [8] = '{adcc_pkg::OFF_SC1, adcc_pkg::OFF_SC2, adcc_pkg::OFF_RH,
      adcc_pkg::OFF_RL, adcc_pkg::OFF_CVH, adcc_pkg::OFF_CVL, adcc_pkg::OFF_CFG, 8'h1C};
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, hardware_trigger_in = 1'b0;
   logic        alternate_clock = 1'b0, async_converter_clock = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, conv_len = 8'h02;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'hF, strb = 4'hF;
   logic [9:0]  model_result = 10'h000;
   logic        awready, wready, bvalid, arready, rvalid, core_done;
   logic [1:0]  bresp, rresp, wresp, rresp_q;
   logic [31:0] rdata;
   logic [9:0]  core_result;
   int          checks = 0, mismatches = 0, starts = 0, aborts = 0, cyc = 0;
   adcc_pkg::adcc_core_req_s core_req;
   adcc_ctrl i_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .hardware_trigger_in(hardware_trigger_in), .alternate_clock(alternate_clock),
      .async_converter_clock(async_converter_clock), .core_done(core_done),
      .core_result(core_result), .core_req(core_req)
   );
   adcc_core_model i_core (
      .aclk(aclk), .aresetn(aresetn), .core_req(core_req), .next_result(model_result),
      .conv_len(conv_len), .core_done(core_done), .core_result(core_result)
   );
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      alternate_clock <= (cyc % 6) < 3;
      async_converter_clock <= (cyc % 10) < 5;
   end
   always @(negedge aclk) begin
      if (core_req.start === 1'b1) starts++;
      if (core_req.abort === 1'b1) aborts++;
   end
   initial begin
      repeat (100000) @(posedge aclk);
      mismatches++;
      final_report();
   end
   // ****************
   // Bus and check tasks
   // ****************
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bail(input int n);
      if (n >= 200) begin
         mismatches++;
         $display("unexpected at %0t: wait ran out", $time);
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 200);
      bready <= 1'b0;
      wresp = bresp;
      bail(n);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 200);
      rready <= 1'b0;
      d = rdata[7:0];
      rresp_q = rresp;
      bail(n);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(d & m, e);
   endtask
   task automatic wait_idle();
      logic [7:0] d;
      int n;
      n = 0;
      do begin
         rd(adcc_pkg::OFF_SC2, d);
         n++;
      end while (d[7] !== 1'b0 && n < 200);
      bail(n);
   endtask
   task automatic convert(input logic [9:0] r);
      model_result <= r;
      wr(adcc_pkg::OFF_SC1, 8'h00);
      wait_idle();
   endtask
   task automatic gap(output int g);
      g = 0;
      do begin
         @(negedge aclk);
         g++;
      end while (core_req.clk_en !== 1'b1 && g < 200);
      bail(g);
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      int g;
      int s0;
      int a0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ROWS[i]) begin
         wr(adcc_pkg::OFF_CFG, ROWS[i].cfg);
         wr(adcc_pkg::OFF_SC2, ROWS[i].sc2);
         wr(adcc_pkg::OFF_CVH, {6'h00, ROWS[i].cv[9:8]});
         wr(adcc_pkg::OFF_CVL, ROWS[i].cv[7:0]);
         chk({5'h00, core_req.low_power, core_req.long_sample, core_req.ten_bit}, {5'h00,
             ROWS[i].cfg[7], ROWS[i].cfg[4], ROWS[i].cfg[3:2] == 2'h2});
         convert(ROWS[i].res);
         rdc(adcc_pkg::OFF_SC1, 8'h80, {ROWS[i].conversion_complete_flag, 7'h00});
         rdc(adcc_pkg::OFF_RH, 8'hFF, {6'h00, ROWS[i].exp[9:8]});
         rdc(adcc_pkg::OFF_RL, 8'hFF, ROWS[i].exp[7:0]);
         rdc(adcc_pkg::OFF_SC1, 8'h80, 8'h00);
      end
      wr(adcc_pkg::OFF_SC2, 8'hF0);
      rdc(adcc_pkg::OFF_SC2, 8'hFF, 8'h70);
      wr(adcc_pkg::OFF_SC2, 8'h00);
      wr(8'h1C, 8'h5A);
      chk({6'h00, wresp}, {6'h00, adcc_pkg::RESP_SLVERR});
      rdc(8'h1C, 8'hFF, 8'h00);
      chk({6'h00, rresp_q}, {6'h00, adcc_pkg::RESP_SLVERR});
      strb = 4'h0;
      wr(adcc_pkg::OFF_CVL, 8'h5A);
      strb = 4'hF;
      rdc(adcc_pkg::OFF_CVL, 8'hFF, 8'h00);
      conv_len <= 8'hFF;
      wr(adcc_pkg::OFF_CFG, 8'h00);
      s0 = starts;
      wr(adcc_pkg::OFF_SC1, 8'h00);
      rdc(adcc_pkg::OFF_SC2, 8'h80, 8'h80);
      for (int s = 0; s < 4; s++) begin
         for (int v = 0; v < 4; v++) begin
            wr(adcc_pkg::OFF_CFG, {1'b0, v[1:0], 3'b000, s[1:0]});
            gap(g);
            gap(g);
            gap(g);
            chk(8'(g), 8'(SRC_T[s] << v));
         end
      end
      wr(adcc_pkg::OFF_CFG, 8'h00);
      a0 = aborts;
      wr(adcc_pkg::OFF_SC1, 8'h00);
      chk(8'(aborts - a0), 8'h01);
      chk(8'(starts - s0), 8'h02);
      wr(adcc_pkg::OFF_SC1, 8'h1F);
      rdc(adcc_pkg::OFF_SC2, 8'h80, 8'h00);
      chk(8'(starts - s0), 8'h02);
      conv_len <= 8'h02;
      wr(adcc_pkg::OFF_SC2, 8'h40);
      s0 = starts;
      wr(adcc_pkg::OFF_SC1, 8'h00);
      rdc(adcc_pkg::OFF_SC2, 8'hFF, 8'h40);
      model_result <= 10'h05A;
      hardware_trigger_in <= 1'b1;
      g = 0;
      while (starts == s0 && g < 200) begin
         @(posedge aclk);
         g++;
      end
      bail(g);
      hardware_trigger_in <= 1'b0;
      wait_idle();
      chk(8'(starts - s0), 8'h01);
      rdc(adcc_pkg::OFF_RL, 8'hFF, 8'h5A);
      wr(adcc_pkg::OFF_SC2, 8'h00);
      wr(adcc_pkg::OFF_CFG, 8'h08);
      convert(10'h111);
      rdc(adcc_pkg::OFF_RH, 8'hFF, 8'h01);
      convert(10'h222);
      rdc(adcc_pkg::OFF_RH, 8'hFF, 8'h01);
      rdc(adcc_pkg::OFF_RL, 8'hFF, 8'h11);
      convert(10'h333);
      rdc(adcc_pkg::OFF_RL, 8'hFF, 8'h33);
      wr(adcc_pkg::OFF_CFG, 8'h00);
      convert(10'h0A1);
      rdc(adcc_pkg::OFF_RH, 8'hFF, 8'h00);
      convert(10'h0B2);
      rdc(adcc_pkg::OFF_RL, 8'hFF, 8'hB2);
      s0 = starts;
      wr(adcc_pkg::OFF_SC1, 8'h20);
      g = 0;
      while (starts - s0 < 3 && g < 200) begin
         @(posedge aclk);
         g++;
      end
      bail(g);
      chk(8'(starts - s0), 8'h03);
      wr(adcc_pkg::OFF_SC1, 8'h1F);
      s0 = starts;
      rdc(adcc_pkg::OFF_SC2, 8'h80, 8'h00);
      chk(8'(starts - s0), 8'h00);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      chk({3'h0, core_req.channel}, {3'h0, adcc_pkg::CHAN_OFF});
      foreach (RST_A[i]) rdc(RST_A[i], 8'hFF, (i == 0) ? 8'h1F : 8'h00);
      final_report();
   end
endmodule // tb
`default_nettype wire
